/* acm_attr_bank.sv */
// Per-channel attribute bank of an analog current input or output module
`timescale 1ns/1ps

module acm_attr_bank
  import acm_pkg::*;
#(
  parameter logic OUTPUT_CLASS = 1'b0,      // 1: output class, 0: input class
  parameter logic [3:0] CHANNELS = 4'h8     // Supported channels, 1 to 8
) (
  input wire logic sys_clk_in,              // System clock, 125 MHz
  input wire logic rst_n_in,                // Asynchronous reset, active low
  input wire logic req_valid_in,            // A get or set request this cycle
  input acm_req_t req_in,                   // The request
  output logic resp_valid_out,              // Answer strobe, one cycle
  output acm_resp_t resp_out,               // The answer
  input wire logic [7:0][15:0] meas_value_in,  // Converter readings, input class
  input wire logic [7:0] range_err_in,      // Reading out of range, input class
  input wire logic [7:0] open_circ_in,      // Loop broken, input class
  input wire logic out_data_valid_in,       // New process data, output class
  input wire logic [7:0][15:0] out_data_in,  // Process data words, output class
  input wire logic fault_in,                // Bus fault: drive the fault values
  output logic [7:0][15:0] drive_value_out,  // Words to the output converters
  output logic [7:0] range_sel_out          // Per channel 1: 4..20 mA range
);

  // Configuration: mode bytes and fault values
  logic [7:0][7:0] mode_reg;                // Mode byte per channel
  logic [7:0][7:0] mode_next;
  logic [7:0][15:0] fallback_reg;           // Fault value per channel
  logic [7:0][15:0] fallback_next;

  // Process state: presented values, diagnostics, drive words
  logic [7:0][15:0] value_reg;              // Attribute data words
  logic [7:0][15:0] value_next;
  logic [7:0][7:0] diag_reg;                // Attribute diagnostic bytes
  logic [7:0][7:0] diag_next;
  logic [7:0][15:0] drive_reg;              // Converter words
  logic [7:0][15:0] drive_next;
  logic [7:0] range_reg;                    // Range select per channel
  logic [7:0] range_next;

  // Answer path
  logic resp_valid_reg;
  logic resp_valid_next;
  acm_resp_t resp_reg;
  acm_resp_t resp_next;

  // Decoded request
  acm_kind_t dec_kind;                      // Addressed bank
  logic [2:0] dec_chan;                     // Addressed channel
  logic dec_supported;                      // Attribute exists
  logic dec_writable;                       // Attribute takes a set
  logic set_ok;                             // A set that will be stored

  // Writable bits of the mode byte for this class
  localparam logic [7:0] MODE_MASK = OUTPUT_CLASS ? ACM_OUT_MODE_MASK : ACM_IN_MODE_MASK;

  // Attribute decoder shared by the get and the set path
  acm_attr_decode u_decode (
    .attr_in(req_in.attr),
    .chan_count_in(CHANNELS),
    .is_output_in(OUTPUT_CLASS),
    .kind_out(dec_kind),
    .chan_out(dec_chan),
    .supported_out(dec_supported),
    .writable_out(dec_writable)
  );

  // Only a set on an existing writable attribute touches storage
  assign set_ok = req_valid_in && req_in.set && dec_writable;

  // Next configuration values
  always_comb begin
    mode_next = mode_reg;
    fallback_next = fallback_reg;
    if (set_ok && (dec_kind == ACM_KIND_MODE)) begin
      // Reserved bits are dropped so they always read back as zero
      mode_next[dec_chan] = req_in.data[7:0] & MODE_MASK;
    end
    if (set_ok && (dec_kind == ACM_KIND_FALLBACK)) begin
      fallback_next[dec_chan] = req_in.data;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg <= {ACM_NUM_CH{ACM_MODE_RESET}};
      fallback_reg <= {ACM_NUM_CH{ACM_FALLBACK_RESET}};
    end else begin
      mode_reg <= mode_next;
      fallback_reg <= fallback_next;
    end
  end

  // Next process values; unsupported positions are held at zero
  always_comb begin
    value_next = value_reg;
    diag_next = {ACM_NUM_CH{ACM_DIAG_RESET}};
    drive_next = {ACM_NUM_CH{ACM_VALUE_RESET}};
    range_next = 8'h00;
    for (int i = 0; i < ACM_NUM_CH; i++) begin
      if (!acm_chan_ok(3'(i), CHANNELS)) begin
        // Channel does not exist on this instance
        value_next[i] = ACM_VALUE_RESET;
      end else if (!OUTPUT_CLASS) begin
        // Input class: readings refreshed every cycle
        value_next[i] = acm_fmt(meas_value_in[i], mode_reg[i][ACM_MODE_FMT_BIT]);
        range_next[i] = mode_reg[i][ACM_MODE_RANGE_BIT];
        if (!mode_reg[i][ACM_MODE_DIAG_DIS_BIT]) begin
          // Diagnostics enabled for this channel
          diag_next[i][ACM_DIAG_RANGE_BIT] = range_err_in[i];
          // A broken loop cannot be told from zero current in 0..20 mA
          diag_next[i][ACM_DIAG_OPEN_BIT] =
            open_circ_in[i] & mode_reg[i][ACM_MODE_RANGE_BIT];
        end
        // Bits 2..7 keep the zero default
      end else begin
        // Output class: process data held until new data arrives
        if (out_data_valid_in) begin
          value_next[i] = out_data_in[i];
        end
        range_next[i] = mode_reg[i][ACM_MODE_RANGE_BIT];
        // The fault value replaces process data while the bus has failed
        drive_next[i] = acm_fmt(fault_in ? fallback_reg[i] : value_reg[i],
                                mode_reg[i][ACM_MODE_FMT_BIT]);
        // Output diagnostic bytes keep the zero default
      end
    end
  end

  // Process registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_reg <= {ACM_NUM_CH{ACM_VALUE_RESET}};
      diag_reg <= {ACM_NUM_CH{ACM_DIAG_RESET}};
      drive_reg <= {ACM_NUM_CH{ACM_VALUE_RESET}};
      range_reg <= 8'h00;
    end else begin
      value_reg <= value_next;
      diag_reg <= diag_next;
      drive_reg <= drive_next;
      range_reg <= range_next;
    end
  end

  // Answer to each request, one cycle later; reads show state before a set
  always_comb begin
    resp_valid_next = req_valid_in;
    resp_next = '0;
    if (req_valid_in) begin
      if (req_in.set) begin
        // Read-only, missing and unsupported targets all refuse the set
        resp_next.ok = dec_writable;
      end else begin
        resp_next.ok = dec_supported;
        case (dec_kind)
          ACM_KIND_COUNT: resp_next.data = {12'h000, CHANNELS};
          ACM_KIND_VALUE: resp_next.data = value_reg[dec_chan];
          ACM_KIND_DIAG: resp_next.data = {8'h00, diag_reg[dec_chan]};
          ACM_KIND_MODE: resp_next.data = {8'h00, mode_reg[dec_chan]};
          ACM_KIND_FALLBACK: resp_next.data = fallback_reg[dec_chan];
          default: resp_next.data = 16'h0000;
        endcase
        if (!dec_supported) begin
          // No data leaks from a refused get
          resp_next.data = 16'h0000;
        end
      end
    end
  end

  // Answer registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_valid_reg <= 1'b0;
      resp_reg <= '0;
    end else begin
      resp_valid_reg <= resp_valid_next;
      resp_reg <= resp_next;
    end
  end

  // Outputs straight from flip-flops
  assign resp_valid_out = resp_valid_reg;
  assign resp_out = resp_reg;
  assign drive_value_out = drive_reg;
  assign range_sel_out = range_reg;

  // Checks on the answer path
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Request and the answer it gets
  sequence get_count_s;
    req_valid_in && !req_in.set && (req_in.attr == ACM_ATTR_CHAN_COUNT);
  endsequence

  sequence set_ro_s;
    req_valid_in && req_in.set &&
      ((dec_kind == ACM_KIND_VALUE) || (dec_kind == ACM_KIND_DIAG) ||
       (dec_kind == ACM_KIND_COUNT));
  endsequence

  sequence set_mode_s;
    req_valid_in && req_in.set && (dec_kind == ACM_KIND_MODE) && dec_supported;
  endsequence

  count_answer_a: assert property (get_count_s |=> resp_valid_out && resp_out.ok &&
    (resp_out.data == {12'h000, CHANNELS}))
    else $error("channel count answer wrong");

  ro_set_reject_a: assert property (set_ro_s |=> resp_valid_out && !resp_out.ok &&
    $stable(mode_reg) && $stable(fallback_reg))
    else $error("set on read-only attribute not refused");

  beyond_count_a: assert property (req_valid_in && req_in.set &&
    (req_in.attr[7:3] == ACM_ATTR_MODE_BASE[7:3]) && !acm_chan_ok(req_in.attr[2:0], CHANNELS)
    |=> !resp_out.ok && $stable(mode_reg))
    else $error("set beyond channel count not refused");

  mode_write_a: assert property (set_mode_s |=> resp_out.ok &&
    (mode_reg[$past(dec_chan)] == ($past(req_in.data[7:0]) & MODE_MASK)))
    else $error("mode write not stored");

  fallback_write_a: assert property (req_valid_in && req_in.set &&
    (dec_kind == ACM_KIND_FALLBACK) && dec_supported
    |=> resp_out.ok && (fallback_reg[$past(dec_chan)] == $past(req_in.data)))
    else $error("fault value write not stored");

  out_diag_zero_a: assert property (OUTPUT_CLASS |-> (diag_reg == '0))
    else $error("output diagnostic byte not zero");

  // A get on a missing attribute or channel
  sequence get_missing_s;
    req_valid_in && !req_in.set && !dec_supported;
  endsequence

  // A refused get must not leak stored data to the master
  get_refused_zero_a: assert property (get_missing_s |=> resp_valid_out && !resp_out.ok &&
    (resp_out.data == 16'h0000))
    else $error("refused get returned data");

  // A set answers with status only, served or refused
  set_no_data_a: assert property (req_valid_in && req_in.set
    |=> resp_valid_out && (resp_out.data == 16'h0000))
    else $error("set answer carries data");

  // Value reads show the word held in the cycle of the request
  value_read_a: assert property (req_valid_in && !req_in.set &&
    (dec_kind == ACM_KIND_VALUE) && dec_supported
    |=> resp_out.ok && (resp_out.data == $past(value_reg[dec_chan])))
    else $error("value read does not match held word");

  // Per channel checks
  for (genvar g = 0; g < ACM_NUM_CH; g++) begin : g_chk
    range_diag_a: assert property (!OUTPUT_CLASS && acm_chan_ok(3'(g), CHANNELS) &&
      rst_n_in && !mode_reg[g][ACM_MODE_DIAG_DIS_BIT]
      |=> diag_reg[g][ACM_DIAG_RANGE_BIT] == $past(range_err_in[g]))
      else $error("range error bit does not follow the reading");

    open_only_420_a: assert property (diag_reg[g][ACM_DIAG_OPEN_BIT]
      |-> $past(mode_reg[g][ACM_MODE_RANGE_BIT]))
      else $error("open circuit flagged outside 4..20 mA");

    diag_reserved_a: assert property (diag_reg[g][7:2] == 6'h00)
      else $error("reserved diagnostic bits set");

    diag_disable_a: assert property (mode_reg[g][ACM_MODE_DIAG_DIS_BIT]
      |=> diag_reg[g][1:0] == 2'b00)
      else $error("diagnostics reported while disabled");

    range_sel_a: assert property (acm_chan_ok(3'(g), CHANNELS)
      |=> range_sel_out[g] == $past(mode_reg[g][ACM_MODE_RANGE_BIT]))
      else $error("range select does not follow mode");

    fmt12_a: assert property (!OUTPUT_CLASS && mode_reg[g][ACM_MODE_FMT_BIT]
      |=> value_reg[g][3:0] == 4'h0)
      else $error("12 bit value not left aligned");

    out_data_a: assert property (OUTPUT_CLASS && acm_chan_ok(3'(g), CHANNELS) &&
      rst_n_in && out_data_valid_in |=> value_reg[g] == $past(out_data_in[g]))
      else $error("process data not held");

    // Positions past the count show nothing at all
    unsupported_quiet_a: assert property (!acm_chan_ok(3'(g), CHANNELS)
      |=> (value_reg[g] == 16'h0000) && !range_sel_out[g] && (diag_reg[g] == 8'h00))
      else $error("unsupported channel shows activity");

    // Reserved mode bits are dropped on every set
    mode_reserved_a: assert property ((mode_reg[g] & ~MODE_MASK) == 8'h00)
      else $error("reserved mode bit stored");

    // In 15 bit format the converter takes the fault value while the bus has failed
    fault_drive_a: assert property (OUTPUT_CLASS && acm_chan_ok(3'(g), CHANNELS) &&
      rst_n_in && fault_in && !mode_reg[g][ACM_MODE_FMT_BIT]
      |=> drive_value_out[g] == $past(fallback_reg[g]))
      else $error("fault value not driven");
  end

endmodule

/* acm_attr_decode.sv */
// Attribute number decoder for the analog current attribute bank
`timescale 1ns/1ps

module acm_attr_decode
  import acm_pkg::*;
(
  input wire logic [7:0] attr_in,        // Requested attribute number
  input wire logic [3:0] chan_count_in,  // Supported channel count
  input wire logic is_output_in,         // 1: output class, 0: input class
  output acm_kind_t kind_out,            // Addressed attribute bank
  output logic [2:0] chan_out,           // Channel position within the bank
  output logic supported_out,            // Attribute exists on this instance
  output logic writable_out              // Attribute takes a set service
);

  // Bank base and channel offset
  always_comb begin
    kind_out = ACM_KIND_NONE;
    chan_out = attr_in[2:0];
    if (attr_in == ACM_ATTR_CHAN_COUNT) begin
      kind_out = ACM_KIND_COUNT;
    end else if ((attr_in & 8'hf8) == ACM_ATTR_VALUE_BASE) begin
      kind_out = ACM_KIND_VALUE;
    end else if ((attr_in & 8'hf8) == ACM_ATTR_DIAG_BASE) begin
      kind_out = ACM_KIND_DIAG;
    end else if ((attr_in & 8'hf8) == ACM_ATTR_MODE_BASE) begin
      kind_out = ACM_KIND_MODE;
    end else if (((attr_in & 8'hf8) == ACM_ATTR_FALLBACK_BASE) && is_output_in) begin
      // Fault values exist only on the output class
      kind_out = ACM_KIND_FALLBACK;
    end else begin
      kind_out = ACM_KIND_NONE;
    end
  end

  // Channel positions beyond the count do not exist at all
  always_comb begin
    case (kind_out)
      ACM_KIND_NONE: supported_out = 1'b0;
      ACM_KIND_COUNT: supported_out = 1'b1;
      default: supported_out = acm_chan_ok(chan_out, chan_count_in);
    endcase
    // Only mode and fault value banks are writable
    writable_out = supported_out &&
                   ((kind_out == ACM_KIND_MODE) || (kind_out == ACM_KIND_FALLBACK));
  end

endmodule

/* acm_master_model.sv */
// Fieldbus master model issuing get and set services to one attribute bank
`timescale 1ns/1ps

module acm_master_model
  import acm_pkg::*;
(
  input wire logic sys_clk_in,     // System clock
  output logic req_valid_out,      // Request strobe to the bank
  output acm_req_t req_out,        // Request to the bank
  input wire logic resp_valid_in,  // Answer strobe from the bank
  input acm_resp_t resp_in         // Answer from the bank
);
  // Idle bus before the first request
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end

  // One service: a one-cycle strobe, then a bounded wait for the answer
  task automatic xfer(input logic set, input logic [7:0] attr, input logic [15:0] data,
                      output logic [16:0] got);
    int n;
    got = 17'h1ffff;  // Stays all ones if no answer comes
    @(posedge sys_clk_in);
    req_valid_out <= 1'b1;
    req_out <= '{set, attr, data};
    @(posedge sys_clk_in);
    req_valid_out <= 1'b0;
    req_out <= ~req_out;  // Released lines must not keep the old value
    for (n = 0; n < 4; n++) begin
      @(posedge sys_clk_in);
      if (resp_valid_in === 1'b1) begin
        got = resp_in;
        break;
      end
    end
  endtask
endmodule

/* acm_pkg.sv */
// Constants, types and helpers shared by the analog current attribute bank
package acm_pkg;

  // Attribute numbers of the per-channel banks
  localparam logic [7:0] ACM_ATTR_CHAN_COUNT = 8'h6f;  // Supported channel count
  localparam logic [7:0] ACM_ATTR_VALUE_BASE = 8'h70;  // Channel data words
  localparam logic [7:0] ACM_ATTR_DIAG_BASE = 8'h78;   // Channel diagnostic bytes
  localparam logic [7:0] ACM_ATTR_MODE_BASE = 8'h80;   // Channel mode bytes
  localparam logic [7:0] ACM_ATTR_FALLBACK_BASE = 8'h88;  // Output fault values

  // Bank geometry
  localparam int ACM_NUM_CH = 8;               // Channel positions per bank
  localparam logic [3:0] ACM_MAX_CH = 4'h8;    // Largest channel count

  // Mode byte fields
  localparam int ACM_MODE_RANGE_BIT = 0;       // 0: 0..20 mA, 1: 4..20 mA
  localparam int ACM_MODE_FMT_BIT = 1;         // 0: 15 bit + sign, 1: 12 bit left aligned
  localparam int ACM_MODE_DIAG_DIS_BIT = 2;    // 0: diagnostics on, 1: off
  localparam logic [7:0] ACM_IN_MODE_MASK = 8'h07;   // Writable input mode bits
  localparam logic [7:0] ACM_OUT_MODE_MASK = 8'h03;  // Writable output mode bits

  // Diagnostic byte fields
  localparam int ACM_DIAG_RANGE_BIT = 0;       // Measurement range error
  localparam int ACM_DIAG_OPEN_BIT = 1;        // Open circuit

  // Value formatting
  localparam logic [15:0] ACM_FMT12_MASK = 16'hfff0;  // Keeps the 12 upper bits

  // Reset values
  localparam logic [7:0] ACM_MODE_RESET = 8'h00;
  localparam logic [15:0] ACM_FALLBACK_RESET = 16'h0000;
  localparam logic [15:0] ACM_VALUE_RESET = 16'h0000;
  localparam logic [7:0] ACM_DIAG_RESET = 8'h00;

  // What an attribute number addresses
  typedef enum logic [2:0] {
    ACM_KIND_NONE,
    ACM_KIND_COUNT,
    ACM_KIND_VALUE,
    ACM_KIND_DIAG,
    ACM_KIND_MODE,
    ACM_KIND_FALLBACK
  } acm_kind_t;

  // A get or set service request
  typedef struct packed {
    logic set;          // 1: set service, 0: get service
    logic [7:0] attr;   // Attribute number
    logic [15:0] data;  // Set data, byte attributes use the low byte
  } acm_req_t;

  // The answer to one request
  typedef struct packed {
    logic ok;           // 1: served, 0: rejected
    logic [15:0] data;  // Get data, zero on a set or a rejection
  } acm_resp_t;

  // Presents a value in the format that the mode byte selects
  function automatic logic [15:0] acm_fmt(input logic [15:0] value, input logic fmt12);
    acm_fmt = fmt12 ? (value & ACM_FMT12_MASK) : value;
  endfunction

  // True when a channel position lies within the supported count
  function automatic logic acm_chan_ok(input logic [2:0] chan, input logic [3:0] count);
    acm_chan_ok = ({1'b0, chan} < count);
  endfunction

endpackage

/* test_analog_current_channel_attributes.sv */
// Self-checking testbench for the analog current attribute bank, both classes
`timescale 1ns/1ps

module test_analog_current_channel_attributes
  import acm_pkg::*;
;
  localparam logic [3:0] CH_IN = 4'h6;  // Input bank supports fewer than eight channels
  logic sys_clk_in;
  logic rst_n_in;
  logic in_req_valid, out_req_valid;  // Request strobes per bank
  acm_req_t in_req, out_req;
  logic in_resp_valid, out_resp_valid;
  acm_resp_t in_resp, out_resp;
  logic [7:0][15:0] meas_value, out_data, in_drive, out_drive;
  logic [7:0] range_err, open_circ, in_range_sel, out_range_sel;
  logic out_data_valid, fault;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  // Clock, 8 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // Both banks share the process inputs so none of them is tied off
  acm_attr_bank #(.OUTPUT_CLASS(1'b0), .CHANNELS(CH_IN)) acm_attr_bank_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(in_req_valid), .req_in(in_req),
    .resp_valid_out(in_resp_valid), .resp_out(in_resp),
    .meas_value_in(meas_value), .range_err_in(range_err), .open_circ_in(open_circ),
    .out_data_valid_in(out_data_valid), .out_data_in(out_data), .fault_in(fault),
    .drive_value_out(in_drive), .range_sel_out(in_range_sel));
  acm_attr_bank #(.OUTPUT_CLASS(1'b1), .CHANNELS(4'h8)) out_acm_attr_bank_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(out_req_valid), .req_in(out_req),
    .resp_valid_out(out_resp_valid), .resp_out(out_resp),
    .meas_value_in(meas_value), .range_err_in(range_err), .open_circ_in(open_circ),
    .out_data_valid_in(out_data_valid), .out_data_in(out_data), .fault_in(fault),
    .drive_value_out(out_drive), .range_sel_out(out_range_sel));
  acm_master_model in_master_i (
    .sys_clk_in(sys_clk_in), .req_valid_out(in_req_valid), .req_out(in_req),
    .resp_valid_in(in_resp_valid), .resp_in(in_resp));
  acm_master_model out_master_i (
    .sys_clk_in(sys_clk_in), .req_valid_out(out_req_valid), .req_out(out_req),
    .resp_valid_in(out_resp_valid), .resp_in(out_resp));

  // Counts and verdict, the only place the run ends
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One comparison of an answer or an output word
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // One service on the chosen bank, answer compared with {ok, data}
  task automatic ask(input logic outb, input logic set, input logic [7:0] attr,
                     input logic [15:0] data, input logic [16:0] exp);
    logic [16:0] got;
    if (outb) begin
      out_master_i.xfer(set, attr, data, got);
    end else begin
      in_master_i.xfer(set, attr, data, got);
    end
    check(got, exp);
  endtask

  // Channel counts and mode bytes, including positions past the count
  task automatic test_modes();
    ask(1'b0, 1'b0, 8'h6f, 16'h0000, 17'h10006);
    ask(1'b1, 1'b0, 8'h6f, 16'h0000, 17'h10008);
    ask(1'b0, 1'b1, 8'h6f, 16'h0003, 17'h00000);
    for (int ch = 0; ch < 8; ch++) begin
      if (ch < 6) begin
        ask(1'b0, 1'b1, 8'h80 + 8'(ch), 16'h12ff, 17'h10000);
        ask(1'b0, 1'b0, 8'h80 + 8'(ch), 16'h0000, 17'h10007);
      end else begin
        ask(1'b0, 1'b1, 8'h80 + 8'(ch), 16'h00ff, 17'h00000);
        ask(1'b0, 1'b0, 8'h78 + 8'(ch), 16'h0000, 17'h00000);
      end
    end
    check({9'h000, in_range_sel}, {9'h000, 8'h3f});
    ask(1'b1, 1'b1, 8'h87, 16'h00ff, 17'h10000);
    ask(1'b1, 1'b0, 8'h87, 16'h0000, 17'h10003);
    $display("test_modes done");
  endtask

  // Measured words in both formats, and a refused write to a reading
  task automatic test_values();
    ask(1'b0, 1'b1, 8'h80, 16'h0000, 17'h10000);
    ask(1'b0, 1'b1, 8'h81, 16'h0002, 17'h10000);
    meas_value[0] <= 16'h8123;
    meas_value[1] <= 16'h1234;
    repeat (3) @(posedge sys_clk_in);
    ask(1'b0, 1'b0, 8'h70, 16'h0000, 17'h18123);
    ask(1'b0, 1'b0, 8'h71, 16'h0000, 17'h11230);
    ask(1'b0, 1'b1, 8'h70, 16'h5555, 17'h00000);
    ask(1'b0, 1'b0, 8'h70, 16'h0000, 17'h18123);
    check({9'h000, in_range_sel}, {9'h000, 8'h3c});
    $display("test_values done");
  endtask

  // Diagnostic bits against range, open loop and the disable bit
  task automatic test_diag();
    ask(1'b0, 1'b1, 8'h81, 16'h0001, 17'h10000);
    ask(1'b0, 1'b1, 8'h82, 16'h0005, 17'h10000);
    range_err <= 8'h05;
    open_circ <= 8'hff;
    repeat (3) @(posedge sys_clk_in);
    ask(1'b0, 1'b0, 8'h78, 16'h0000, 17'h10001);
    ask(1'b0, 1'b0, 8'h79, 16'h0000, 17'h10002);
    ask(1'b0, 1'b0, 8'h7a, 16'h0000, 17'h10000);
    range_err <= 8'h00;
    repeat (3) @(posedge sys_clk_in);
    ask(1'b0, 1'b0, 8'h78, 16'h0000, 17'h10000);
    ask(1'b0, 1'b0, 8'h79, 16'h0000, 17'h10002);
    $display("test_diag done");
  endtask

  // Output words, reserved diagnostics and fault values on a bus fault
  task automatic test_output();
    ask(1'b1, 1'b1, 8'h80, 16'h0002, 17'h10000);
    ask(1'b1, 1'b1, 8'h81, 16'h0000, 17'h10000);
    out_data[0] <= 16'h1237;
    out_data[1] <= 16'hfedc;
    out_data_valid <= 1'b1;
    @(posedge sys_clk_in);
    out_data_valid <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check({1'b0, out_drive[0]}, 17'h01230);
    check({1'b0, out_drive[1]}, 17'h0fedc);
    check({9'h000, out_range_sel}, {9'h000, 8'h80});
    check({16'h0000, |in_drive}, 17'h00000);
    ask(1'b1, 1'b0, 8'h70, 16'h0000, 17'h11237);
    ask(1'b1, 1'b0, 8'h71, 16'h0000, 17'h1fedc);
    ask(1'b1, 1'b1, 8'h71, 16'h0000, 17'h00000);
    ask(1'b1, 1'b0, 8'h78, 16'h0000, 17'h10000);
    ask(1'b1, 1'b1, 8'h88, 16'h8001, 17'h10000);
    ask(1'b1, 1'b1, 8'h89, 16'h4567, 17'h10000);
    ask(1'b1, 1'b0, 8'h88, 16'h0000, 17'h18001);
    ask(1'b0, 1'b1, 8'h88, 16'h1111, 17'h00000);
    fault <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    check({1'b0, out_drive[0]}, 17'h08000);
    check({1'b0, out_drive[1]}, 17'h04567);
    fault <= 1'b0;
    $display("test_output done");
  endtask

  // Reset in mid-run brings the stored configuration back to zero
  task automatic test_reset();
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    check({9'h000, out_range_sel}, 17'h00000);
    ask(1'b0, 1'b0, 8'h81, 16'h0000, 17'h10000);
    ask(1'b1, 1'b0, 8'h88, 16'h0000, 17'h10000);
    ask(1'b0, 1'b0, 8'h70, 16'h0000, 17'h18123);
    $display("test_reset done");
  endtask

  // Watchdog: a hang counts as a mismatch and ends the run
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  // Main sequence: reset for 20 cycles, then the scenarios
  initial begin
    rst_n_in = 1'b0;
    meas_value = '0;
    out_data = '0;
    range_err = 8'h00;
    open_circ = 8'h00;
    out_data_valid = 1'b0;
    fault = 1'b0;
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    test_modes();
    test_values();
    test_diag();
    test_output();
    test_reset();
    final_report();
  end
endmodule
